// ===== rtl/dofs_defines.vh
// Constants for the digital output function select block
`ifndef DOFS_DEFINES_VH
`define DOFS_DEFINES_VH

// ****************************************
// Object indexes
// ****************************************
`define DOFS_IDX_SUMMARY 16'h00c2
`define DOFS_IDX_FUNC1 16'h00c4
`define DOFS_IDX_THR1 16'h00c6
`define DOFS_IDX_USER1 16'h00cc
`define DOFS_IDX_FUNC2 16'h00ce
`define DOFS_IDX_THR2 16'h00d0
`define DOFS_IDX_USER2 16'h00d6

// ****************************************
// Reset values and field positions
// ****************************************
`define DOFS_FUNC_RST 8'h00
`define DOFS_THR_RST 64'h0000000000000000
`define DOFS_USER_RST 1'b0
`define DOFS_SUM_FIRST_BIT 1
`define DOFS_SUM_SECOND_BIT 0

// ****************************************
// Function codes
// ****************************************
`define DOFS_M_USER 8'h00
`define DOFS_M_MAINS 8'h01
`define DOFS_M_SWLIM 8'h02
`define DOFS_M_MOVED 8'h03
`define DOFS_M_INPOS 8'h04
`define DOFS_M_POSGT 8'h05
`define DOFS_M_POSLT 8'h06
`define DOFS_M_WARN 8'h07
`define DOFS_M_ENAB 8'h08
`define DOFS_M_RSVD 8'h09
`define DOFS_M_BRAKE 8'h0a
`define DOFS_M_FAULT 8'h0b
`define DOFS_M_VELGT 8'h0c
`define DOFS_M_VELLT 8'h0d
`define DOFS_M_HOMED 8'h0e
`define DOFS_M_LIMSW 8'h0f
`define DOFS_M_CMDBUF 8'h10
`define DOFS_M_TASKPOS 8'h11
`define DOFS_M_UNASGN 8'h12
`define DOFS_M_INDEX 8'h13
`define DOFS_M_NOSTOP 8'h14
`define DOFS_M_PSFAULT 8'h15

`endif

// ===== rtl/dofs_top.v
// Digital output function select: two outputs, their modes, thresholds and summary
//
// Contract
// - Summary word: first output left, second right
// - Per-output mode field, resets to zero
// - Codes 1-3: mains ready, soft limit, move done
// - Codes 4-6: in position, above, below threshold
// - Codes 7,8,10,11 status; code 9 reserved
// - Codes 12-13: absolute velocity above/below threshold
// - Codes 14-17: homed, limit OR, buffer, task
// - Codes 19-21: index, no stop, stage fault
// - Signed 64-bit threshold per output, resets zero
// - Position modes accept threshold within position limits
// - Velocity modes accept zero to velocity maximum
// - Other modes accept threshold zero only
// - Changed mode clears that output's threshold
// - User mode follows writable user level bit
`timescale 1ns/1ns
`default_nettype none
`include "dofs_defines.vh"

module dofs_top #(
    parameter LIM_W = 8
) (
    // Clock and reset
    input wire clk_sys_in,
    input wire rst_b_in,
    // Object access port
    input wire [15:0] obj_idx_in,
    input wire obj_wr_in,
    input wire obj_rd_in,
    input wire [63:0] obj_wdata_in,
    output reg [63:0] obj_rdata_out,
    output reg obj_ack_out,
    output reg obj_err_out,
    // Drive conditions
    input wire mains_ready_in,
    input wire soft_limit_in,
    input wire move_done_in,
    input wire in_position_in,
    input wire warning_in,
    input wire drive_enabled_in,
    input wire brake_in,
    input wire fault_in,
    input wire homed_in,
    input wire [LIM_W-1:0] limit_switch_flags_in,
    input wire cmd_buffer_active_in,
    input wire task_in_position_in,
    input wire index_pulse_in,
    input wire no_stop_active_in,
    input wire stage_fault_in,
    // Position and velocity with their limits
    input wire [63:0] position_in,
    input wire [63:0] velocity_in,
    input wire [63:0] position_min_in,
    input wire [63:0] position_max_in,
    input wire [63:0] velocity_max_in,
    // Output levels
    output reg first_output_out,
    output reg second_output_out
);

    // ****************************************
    // Decode helpers
    // ****************************************

    // Assigned codes only; 18 and anything past 21 are refused
    function mode_ok;
        input [63:0] v;
        begin
            mode_ok = (v <= {56'h0, `DOFS_M_PSFAULT}) &&
                      (v != {56'h0, `DOFS_M_UNASGN});
        end
    endfunction

    // Threshold range depends on the mode currently held
    function thr_ok;
        input [7:0] m;
        input [63:0] v;
        input [63:0] pmin;
        input [63:0] pmax;
        input [63:0] vmax;
        begin
            case (m)
                `DOFS_M_INPOS, `DOFS_M_POSGT, `DOFS_M_POSLT: begin
                    thr_ok = ($signed(v) >= $signed(pmin)) &&
                             ($signed(v) <= $signed(pmax));
                end
                `DOFS_M_VELGT, `DOFS_M_VELLT: begin
                    thr_ok = ($signed(v) >= $signed(64'h0)) &&
                             ($signed(v) <= $signed(vmax));
                end
                default: begin
                    thr_ok = (v == 64'h0);
                end
            endcase
        end
    endfunction

    // ****************************************
    // Shared conditions
    // ****************************************

    // Magnitude of velocity; most negative value wraps to itself
    wire [63:0] vel_abs = velocity_in[63] ? (~velocity_in + 64'h1) : velocity_in;
    wire lim_any = |limit_switch_flags_in;

    // ****************************************
    // Registers of both outputs
    // ****************************************
    reg [7:0] func_sel [0:1];
    reg [63:0] thr_val [0:1];
    reg [1:0] user_level;
    wire [1:0] out_level;
    wire [1:0] hit_func;
    wire [1:0] hit_thr;
    wire [1:0] hit_user;
    integer i;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gen_out
            wire [15:0] base_func = (g == 0) ? `DOFS_IDX_FUNC1 : `DOFS_IDX_FUNC2;
            wire [15:0] base_thr = (g == 0) ? `DOFS_IDX_THR1 : `DOFS_IDX_THR2;
            wire [15:0] base_user = (g == 0) ? `DOFS_IDX_USER1 : `DOFS_IDX_USER2;
            assign hit_func[g] = (obj_idx_in == base_func);
            assign hit_thr[g] = (obj_idx_in == base_thr);
            assign hit_user[g] = (obj_idx_in == base_user);

            // Condition picked by the mode; reserved and unused codes give 0
            reg pick;
            always @* begin
                pick = 1'b0;
                case (func_sel[g])
                    `DOFS_M_USER: pick = user_level[g];
                    `DOFS_M_MAINS: pick = mains_ready_in;
                    `DOFS_M_SWLIM: pick = soft_limit_in;
                    `DOFS_M_MOVED: pick = move_done_in;
                    `DOFS_M_INPOS: pick = in_position_in;
                    `DOFS_M_POSGT: pick = $signed(position_in) > $signed(thr_val[g]);
                    `DOFS_M_POSLT: pick = $signed(position_in) < $signed(thr_val[g]);
                    `DOFS_M_WARN: pick = warning_in;
                    `DOFS_M_ENAB: pick = drive_enabled_in;
                    `DOFS_M_RSVD: pick = 1'b0;
                    `DOFS_M_BRAKE: pick = brake_in;
                    `DOFS_M_FAULT: pick = fault_in;
                    `DOFS_M_VELGT: pick = vel_abs > thr_val[g];
                    `DOFS_M_VELLT: pick = vel_abs < thr_val[g];
                    `DOFS_M_HOMED: pick = homed_in;
                    `DOFS_M_LIMSW: pick = lim_any;
                    `DOFS_M_CMDBUF: pick = cmd_buffer_active_in;
                    `DOFS_M_TASKPOS: pick = task_in_position_in;
                    `DOFS_M_INDEX: pick = index_pulse_in;
                    `DOFS_M_NOSTOP: pick = no_stop_active_in;
                    `DOFS_M_PSFAULT: pick = stage_fault_in;
                    default: pick = 1'b0;
                endcase
            end
            assign out_level[g] = pick;
        end
    endgenerate

    // Object writes for both outputs in one process, so each register has one driver;
    // a changed mode wipes the threshold so a stale value never arms a comparison
    always @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (i = 0; i < 2; i = i + 1) begin
                func_sel[i] <= `DOFS_FUNC_RST;
                thr_val[i] <= `DOFS_THR_RST;
                user_level[i] <= `DOFS_USER_RST;
            end
        end else begin
            for (i = 0; i < 2; i = i + 1) begin
                if (obj_wr_in && hit_func[i]) begin
                    if (mode_ok(obj_wdata_in)) begin
                        func_sel[i] <= obj_wdata_in[7:0];
                        if (obj_wdata_in[7:0] != func_sel[i]) begin
                            thr_val[i] <= `DOFS_THR_RST;
                        end
                    end
                end else if (obj_wr_in && hit_thr[i]) begin
                    if (thr_ok(func_sel[i], obj_wdata_in, position_min_in,
                               position_max_in, velocity_max_in)) begin
                        thr_val[i] <= obj_wdata_in;
                    end
                end else if (obj_wr_in && hit_user[i]) begin
                    user_level[i] <= obj_wdata_in[0];
                end
            end
        end
    end

    // ****************************************
    // Output flops
    // ****************************************

    // One cycle of latency from condition to pin
    always @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            first_output_out <= 1'b0;
            second_output_out <= 1'b0;
        end else begin
            first_output_out <= out_level[0];
            second_output_out <= out_level[1];
        end
    end

    // ****************************************
    // Object access answer
    // ****************************************
    wire hit_sum = (obj_idx_in == `DOFS_IDX_SUMMARY);
    wire mapped = hit_sum | (|hit_func) | (|hit_thr) | (|hit_user);
    reg wr_bad;
    reg [63:0] next_rdata;

    // Refusal of a write: unmapped, read-only, or value out of range
    always @* begin
        wr_bad = !mapped || hit_sum;
        if (hit_func[0] || hit_func[1]) begin
            wr_bad = !mode_ok(obj_wdata_in);
        end else if (hit_thr[0] || hit_thr[1]) begin
            wr_bad = !thr_ok(hit_thr[0] ? func_sel[0] : func_sel[1], obj_wdata_in,
                             position_min_in, position_max_in,
                             velocity_max_in);
        end
    end

    // Read mux; summary shows the pin levels as driven
    always @* begin
        next_rdata = 64'h0;
        if (hit_sum) begin
            next_rdata[`DOFS_SUM_FIRST_BIT] = first_output_out;
            next_rdata[`DOFS_SUM_SECOND_BIT] = second_output_out;
        end else if (hit_func[0]) begin
            next_rdata[7:0] = func_sel[0];
        end else if (hit_func[1]) begin
            next_rdata[7:0] = func_sel[1];
        end else if (hit_thr[0]) begin
            next_rdata = thr_val[0];
        end else if (hit_thr[1]) begin
            next_rdata = thr_val[1];
        end else if (hit_user[0]) begin
            next_rdata[0] = user_level[0];
        end else if (hit_user[1]) begin
            next_rdata[0] = user_level[1];
        end
    end

    // Answer one cycle after the strobe; write wins if both strobes rise
    always @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            obj_rdata_out <= 64'h0;
            obj_ack_out <= 1'b0;
            obj_err_out <= 1'b0;
        end else begin
            obj_ack_out <= obj_wr_in | obj_rd_in;
            if (obj_wr_in) begin
                obj_err_out <= wr_bad;
            end else if (obj_rd_in) begin
                obj_err_out <= !mapped;
                obj_rdata_out <= next_rdata;
            end else begin
                obj_err_out <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// ===== tb/dofs_chk_sva.sv
// Port checker for the output function select block
`timescale 1ns/1ns
`default_nettype none
`include "dofs_defines.vh"
module dofs_chk (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    // Object port
    input wire logic [15:0] obj_idx_in,
    input wire logic obj_wr_in,
    input wire logic obj_rd_in,
    input wire logic [63:0] obj_wdata_in,
    input wire logic [63:0] obj_rdata_out,
    input wire logic obj_ack_out,
    input wire logic obj_err_out,
    // Output levels
    input wire logic first_output_out,
    input wire logic second_output_out
);
    // ****
    // Access properties
    // ****
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);
    // Any strobe, and a write to either mode field
    wire acc = obj_wr_in | obj_rd_in;
    wire mw = obj_wr_in && obj_idx_in inside {`DOFS_IDX_FUNC1, `DOFS_IDX_FUNC2};
    wire map = obj_idx_in inside {16'h00c2, 16'h00c4, 16'h00c6, 16'h00cc, 16'h00ce,
        16'h00d0, 16'h00d6};
    a_ack_next: assert property (acc |=> obj_ack_out) else $error("ack missing");
    a_ack_idle: assert property (!acc |=> !obj_ack_out) else $error("stray ack");
    a_err_ack: assert property (obj_err_out |-> obj_ack_out) else $error("err without ack");
    a_rdata_hold: assert property (!obj_rd_in |=> $stable(obj_rdata_out)) else $error("rdata moved");
    a_sum_ro: assert property (obj_wr_in && obj_idx_in == 16'hc2 |=> obj_err_out)
        else $error("summary write taken");
    a_unmapped_err: assert property (acc && !map |=> obj_err_out) else $error("unmapped taken");
    a_mode_bad: assert property (mw && (obj_wdata_in > 64'h15 || obj_wdata_in == 64'h12)
        |=> obj_err_out) else $error("bad mode taken");
    a_mode_ok: assert property (mw && obj_wdata_in <= 64'h15 && obj_wdata_in != 64'h12
        |=> !obj_err_out) else $error("good mode refused");
    a_sum_bits: assert property (obj_rd_in && !obj_wr_in && obj_idx_in == 16'hc2 |=>
        obj_rdata_out[1:0] == {$past(first_output_out), $past(second_output_out)})
        else $error("summary bits wrong");
endmodule
`default_nettype wire

// ===== tb/dofs_host.sv
// Configuring host model driving the object port
`timescale 1ns/1ns
`default_nettype none
module dofs_host (
    // Clock
    input wire logic clk_sys_in,
    // Object requests
    output var logic [15:0] obj_idx_out,
    output var logic obj_wr_out,
    output var logic obj_rd_out,
    output var logic [63:0] obj_wdata_out
);
    // Idle port; released data is inverted so stale data never passes for valid
    initial begin
        obj_idx_out = 16'h0000;
        obj_wr_out = 1'b0;
        obj_rd_out = 1'b0;
        obj_wdata_out = 64'h0;
    end
    // One access: strobe held across exactly one rising edge
    task automatic acc(input logic w, input logic [15:0] i, input logic [63:0] d);
        @(negedge clk_sys_in);
        obj_idx_out <= i;
        obj_wr_out <= w;
        obj_rd_out <= !w;
        obj_wdata_out <= d;
        @(negedge clk_sys_in);
        obj_wr_out <= 1'b0;
        obj_rd_out <= 1'b0;
        obj_wdata_out <= ~d;
    endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the output function select block
`timescale 1ns/1ns
`default_nettype none
`include "dofs_defines.vh"
module tb;
    // ****
    // Signals
    // ****
    logic clk_sys_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [15:0] idx;
    logic wr, rd, ack, err, o1, o2, u1 = 1'b0, u2;
    logic [63:0] wd, rdat, lim, t;
    logic [13:0] c = 14'h0;
    logic [7:0] fl = 8'h0, cm = 8'h0;
    logic signed [63:0] pos = 64'h0, vel = 64'h0;
    logic [65:0] q[$], e;
    logic [31:0] s = 32'h685652e0, r;
    int error_cnt = 0, n_checks = 0;
    dofs_host host_u (.clk_sys_in, .obj_idx_out(idx), .obj_wr_out(wr), .obj_rd_out(rd),
        .obj_wdata_out(wd));
    dofs_top #(.LIM_W(8)) dut_u (.clk_sys_in, .rst_b_in, .obj_idx_in(idx), .obj_wr_in(wr),
        .obj_rd_in(rd), .obj_wdata_in(wd), .obj_rdata_out(rdat), .obj_ack_out(ack),
        .obj_err_out(err), .mains_ready_in(c[0]), .soft_limit_in(c[1]), .move_done_in(c[2]),
        .in_position_in(c[3]), .warning_in(c[4]), .drive_enabled_in(c[5]), .brake_in(c[6]),
        .fault_in(c[7]), .homed_in(c[8]), .limit_switch_flags_in(fl),
        .cmd_buffer_active_in(c[9]), .task_in_position_in(c[10]), .index_pulse_in(c[11]),
        .no_stop_active_in(c[12]), .stage_fault_in(c[13]), .position_in(pos),
        .velocity_in(vel), .position_min_in(-64'h3e8), .position_max_in(64'h3e8),
        .velocity_max_in(64'h1f4), .first_output_out(o1), .second_output_out(o2));
    initial forever #5 clk_sys_in = ~clk_sys_in;
    function automatic logic [31:0] rnd();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // Expected first output level for mode m and threshold th
    function automatic logic fx(input logic [7:0] m, input logic signed [63:0] th);
        case (m)
            8'h00: fx = u1;
            8'h01, 8'h02, 8'h03, 8'h04: fx = c[m - 8'h01];
            8'h05: fx = pos > th;
            8'h06: fx = pos < th;
            8'h07, 8'h08: fx = c[m - 8'h03];
            8'h0a, 8'h0b: fx = c[m - 8'h04];
            8'h0c: fx = (vel < 0 ? -vel : vel) > th;
            8'h0d: fx = (vel < 0 ? -vel : vel) < th;
            8'h0e: fx = c[8];
            8'h0f: fx = |fl;
            8'h10, 8'h11: fx = c[m - 8'h07];
            8'h13, 8'h14, 8'h15: fx = c[m - 8'h08];
            default: fx = 1'b0;
        endcase
    endfunction
    task automatic chk(input string n, input logic [63:0] x, input logic [63:0] g);
        n_checks++;
        if (g !== x) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", n, x, g);
        end
    endtask
    // Access with its answer noted as {check rdata, err, rdata}
    task automatic op(input logic w, input logic [15:0] i, input logic [63:0] d,
        input logic er, input logic [63:0] x);
        q.push_back({!w && !er, er, x});
        host_u.acc(w, i, d);
    endtask
    // Answer watcher: oldest note against each ack
    always @(negedge clk_sys_in) begin
        if (ack !== 1'b0 && rst_b_in) begin
            chk("queue", 64'h1, {63'h0, q.size() != 0});
            e = q.pop_front();
            chk("err", {63'h0, e[64]}, {63'h0, err});
            if (e[65]) chk("rdata", e[63:0], rdat);
        end
    end
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Hang guard, far beyond the expected run
    initial begin
        #200000;
        error_cnt++;
        test_done();
    end
    initial begin
        repeat (16) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        rst_b_in = 1'b1;
        op(0, `DOFS_IDX_FUNC1, 0, 0, 0);
        op(0, `DOFS_IDX_THR2, 0, 0, 0);
        op(1, `DOFS_IDX_SUMMARY, 0, 1, 0);
        op(0, 16'h00c3, 0, 1, 0);
        op(1, `DOFS_IDX_THR2, 64'h1, 1, 0);
        for (int m = 0; m < 23; m++) begin
            op(1, `DOFS_IDX_FUNC1, 64'(m), m == 18 || m == 22, 0);
            if (m < 18 || m > 18 && m < 22) cm = 8'(m);
            op(0, `DOFS_IDX_FUNC1, 0, 0, cm);
            op(0, `DOFS_IDX_THR1, 0, 0, 0);
            t = 64'h0;
            lim = cm > 8'h06 ? 64'h1f4 : 64'h3e8;
            // Threshold mode is selected before any nonzero value
            op(1, `DOFS_IDX_THR1, lim + 1, 1, 0);
            if (cm inside {4, 5, 6, 12, 13}) begin
                op(1, `DOFS_IDX_THR1, cm > 8'h06 ? -64'h1 : -lim - 1, 1, 0);
                op(1, `DOFS_IDX_THR1, lim, 0, 0);
                t = 64'h64;
                op(1, `DOFS_IDX_THR1, t, 0, 0);
                op(0, `DOFS_IDX_THR1, 0, 0, t);
            end
            repeat (4) begin
                r = rnd();
                u1 = r[0];
                u2 = r[1];
                op(1, `DOFS_IDX_USER1, {63'h0, u1}, 0, 0);
                op(1, `DOFS_IDX_USER2, {63'h0, u2}, 0, 0);
                @(negedge clk_sys_in);
                r = rnd();
                c = r[13:0];
                fl = r[21:14];
                pos = {32'h0, rnd() % 32'h190} - 64'hc8;
                vel = {32'h0, rnd() % 32'h258} - 64'h12c;
                @(negedge clk_sys_in);
                chk("out1", {63'h0, fx(cm, t)}, {63'h0, o1});
                chk("out2", {63'h0, u2}, {63'h0, o2});
                op(0, `DOFS_IDX_SUMMARY, 0, 0, {62'h0, fx(cm, t), u2});
            end
        end
        // Second output: compare mode, refusals, mode change, then a mid-run reset
        op(1, `DOFS_IDX_FUNC2, 64'h5, 0, 0);
        op(1, `DOFS_IDX_THR2, -64'h3e9, 1, 0);
        op(1, `DOFS_IDX_THR2, -64'h32, 0, 0);
        op(1, `DOFS_IDX_FUNC2, 64'h12, 1, 0);
        op(0, `DOFS_IDX_FUNC2, 0, 0, 64'h5);
        op(0, `DOFS_IDX_THR2, 0, 0, -64'h32);
        repeat (4) begin
            @(negedge clk_sys_in);
            pos = {32'h0, rnd() % 32'h190} - 64'hc8;
            @(negedge clk_sys_in);
            chk("out2", {63'h0, pos > -64'sh32}, {63'h0, o2});
        end
        op(1, `DOFS_IDX_FUNC2, 64'hc, 0, 0);
        op(0, `DOFS_IDX_THR2, 0, 0, 0);
        op(1, `DOFS_IDX_THR2, 64'h1f4, 0, 0);
        @(negedge clk_sys_in);
        rst_b_in = 1'b0;
        repeat (2) @(negedge clk_sys_in);
        rst_b_in = 1'b1;
        op(0, `DOFS_IDX_FUNC1, 0, 0, 0);
        op(0, `DOFS_IDX_FUNC2, 0, 0, 0);
        op(0, `DOFS_IDX_THR2, 0, 0, 0);
        chk("rst out2", 64'h0, {63'h0, o2});
        repeat (3) @(negedge clk_sys_in);
        chk("pending", 64'h0, 64'(q.size()));
        test_done();
    end
endmodule
bind dofs_top dofs_chk chk_u (.clk_sys_in, .rst_b_in, .obj_idx_in, .obj_wr_in, .obj_rd_in,
    .obj_wdata_in, .obj_rdata_out, .obj_ack_out, .obj_err_out, .first_output_out,
    .second_output_out);
`default_nettype wire
